// [hw/sbb_pkg.sv]
package sbb_pkg;

    // Register byte offsets
    localparam logic [7:0] SBB_OFF_CTRL    = 8'h00;
    localparam logic [7:0] SBB_OFF_CMD     = 8'h04;
    localparam logic [7:0] SBB_OFF_STATUS  = 8'h08;
    localparam logic [7:0] SBB_OFF_IOMON   = 8'h0c;
    localparam logic [7:0] SBB_OFF_BKDELAY = 8'h10;

    // Control register fields
    localparam int SBB_CTRL_STOP_DB     = 0;  // stop_method_select: dynamic brake
    localparam int SBB_CTRL_MOTION_BUSY = 1;  // an action command is executing
    localparam int SBB_CTRL_UTIL_MODE   = 2;  // utility function mode entered
    localparam int SBB_CTRL_UTIL_MOVE   = 3;  // jog/search/tuning style utility running
    localparam int SBB_CTRL_MAIN_PWR    = 4;  // main circuit power present
    localparam logic [4:0] SBB_CTRL_RESET = 5'h10;

    // Host command codes
    localparam logic [7:0] SBB_CMD_SERVO_ON  = 8'h31;
    localparam logic [7:0] SBB_CMD_SERVO_OFF = 8'h32;
    localparam logic [7:0] SBB_CMD_ALM_CLR   = 8'h06;
    localparam logic [7:0] SBB_CMD_NOP       = 8'h00;

    // IO monitor field position of the baseblock flag
    localparam int SBB_IOMON_HBB = 10;

    // Brake-to-servo-off delay after reset, in cycles
    localparam logic [23:0] SBB_BKDELAY_RESET = 24'h000000;

    // Timing, figures as printed, and the clock
    localparam real SBB_CLK_MHZ       = 40.0;
    localparam real SBB_FILT_MS       = 0.5;
    localparam real SBB_POWER_OFF_MS  = 20.0;
    localparam real SBB_MISMATCH_S    = 10.0;
    localparam int  SBB_FILT_CYC      = int'(SBB_FILT_MS * SBB_CLK_MHZ * 1000.0);
    localparam int  SBB_POWER_OFF_CYC = int'(SBB_POWER_OFF_MS * SBB_CLK_MHZ * 1000.0);
    localparam int  SBB_MISMATCH_CYC  = int'(SBB_MISMATCH_S * SBB_CLK_MHZ * 1.0e6);

    // Supervisory states
    typedef enum logic [1:0] {
        SBB_ST_OFF,
        SBB_ST_RUN,
        SBB_ST_HARDWIRED_BASEBLOCK,
        SBB_ST_BB
    } sbb_state_t;

    // Status word seen by software
    typedef struct packed {
        logic [1:0] safety_input_monitor;
        logic       utility_locked;
        logic       input_timing_alarm;
        logic       command_warning;
        logic       hardwired_baseblock;
        logic       servo_on_status;
    } sbb_status_t;

    // Outputs to the power stage
    typedef struct packed {
        logic motor_power;
        logic brake_release_out;
        logic dynamic_brake;
        logic external_device_monitor_out;
    } sbb_drive_t;

endpackage : sbb_pkg

// [hw/sbb_off_filter.sv]
`timescale 1ns/1ps
`default_nettype none

// Suppresses short OFF pulses on one safety channel
module sbb_off_filter #(
    parameter int FILT_CYC = sbb_pkg::SBB_FILT_CYC,
    parameter int CW       = 16
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Channel
    input  wire logic raw_on,
    output logic      filt_on
);
    import sbb_pkg::*;

    localparam logic [CW-1:0] LIMIT = CW'(FILT_CYC);

    logic [CW-1:0] low_cnt;
    wire           expired = (low_cnt == LIMIT);

    // OFF accepted only once low longer than the limit; ON taken at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt <= '0;
            filt_on <= 1'b0;
        end else if (raw_on) begin
            low_cnt <= '0;
            filt_on <= 1'b1;
        end else if (expired) begin
            filt_on <= 1'b0;
        end else begin
            low_cnt <= low_cnt + 1'b1;
        end
    end

endmodule : sbb_off_filter

`default_nettype wire

// [hw/sbb_safety_baseblock.sv]
`timescale 1ns/1ps
`default_nettype none

module sbb_safety_baseblock #(
    parameter int FILT_CYC     = sbb_pkg::SBB_FILT_CYC,
    parameter int MISMATCH_CYC = sbb_pkg::SBB_MISMATCH_CYC
) (
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // Safety unit inputs, low requests baseblock
    input  wire logic        safety_request_a_n,
    input  wire logic        safety_request_b_n,
    // Power stage
    output sbb_pkg::sbb_drive_t drive,
    // Utility operation permit
    output logic             utility_enable
);
    import sbb_pkg::*;

    // Safety channels with short-pulse suppression
    // Filters wake up OFF, so a power-up always passes through baseblock first
    logic [1:0] raw_on;
    logic [1:0] filt_on;
    assign raw_on = {safety_request_b_n, safety_request_a_n};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_chan
            sbb_off_filter #(
                .FILT_CYC (FILT_CYC),
                .CW       (32)
            ) u_filt (
                .pclk    (pclk),
                .presetn (presetn),
                .raw_on  (raw_on[gi]),
                .filt_on (filt_on[gi])
            );
        end
    endgenerate

    // Registers
    logic [4:0]  ctrl;
    logic [23:0] bk_delay;
    sbb_state_t  state;
    sbb_state_t  next_state;
    logic        son_while_bb;
    logic        cmd_warning;
    logic        timing_alarm;
    logic        util_locked;
    logic [31:0] mismatch_cnt;
    logic [23:0] off_delay_cnt;
    sbb_drive_t  next_drive;

    // APB decode
    wire access   = psel & penable;
    wire wr       = access & pwrite;
    wire hit_ctrl = (paddr == SBB_OFF_CTRL);
    wire hit_cmd  = (paddr == SBB_OFF_CMD);
    wire hit_stat = (paddr == SBB_OFF_STATUS);
    wire hit_iom  = (paddr == SBB_OFF_IOMON);
    wire hit_bkd  = (paddr == SBB_OFF_BKDELAY);
    wire mapped   = hit_ctrl | hit_cmd | hit_stat | hit_iom | hit_bkd;

    // Command strobe: one cycle per write to the command register
    // Any code but servo-on counts as the different command that re-arms servo-on
    wire [7:0] cmd_code   = pwdata[7:0];
    wire       cmd_valid  = wr & hit_cmd;
    wire       cmd_son    = cmd_valid & (cmd_code == SBB_CMD_SERVO_ON);
    wire       cmd_soff   = cmd_valid & (cmd_code == SBB_CMD_SERVO_OFF);
    wire       cmd_aclr   = cmd_valid & (cmd_code == SBB_CMD_ALM_CLR);
    wire       cmd_other  = cmd_valid & ~cmd_son;

    // Control bits
    wire stop_method_select = ctrl[SBB_CTRL_STOP_DB];
    wire motion_busy        = ctrl[SBB_CTRL_MOTION_BUSY];
    wire util_mode          = ctrl[SBB_CTRL_UTIL_MODE];
    wire util_move          = ctrl[SBB_CTRL_UTIL_MOVE];
    wire main_pwr           = ctrl[SBB_CTRL_MAIN_PWR];

    // Baseblock request and entry
    wire hardwired_baseblock_req   = ~filt_on[0] | ~filt_on[1];
    wire both_off   = ~filt_on[0] & ~filt_on[1];
    wire in_hardwired_baseblock    = (state == SBB_ST_HARDWIRED_BASEBLOCK);
    wire enter_hardwired_baseblock = hardwired_baseblock_req & ~in_hardwired_baseblock;
    wire was_active = (state == SBB_ST_RUN) | motion_busy;
    wire off_delay  = (off_delay_cnt != '0);

    // Servo-on accepted only from a clean plain-baseblock or servo-off state
    wire son_ok = ~cmd_warning & ~util_locked & ~timing_alarm;

    // Next state
    always_comb begin
        next_state = state;
        case (state)
            SBB_ST_OFF: begin
                if (cmd_son && son_ok) begin
                    next_state = SBB_ST_RUN;
                end
            end
            SBB_ST_RUN: begin
                if (cmd_soff) begin
                    next_state = SBB_ST_OFF;
                end
            end
            SBB_ST_HARDWIRED_BASEBLOCK: begin
                // Hold without main power until servo-off
                if (!hardwired_baseblock_req && (main_pwr || cmd_soff)) begin
                    next_state = SBB_ST_BB;
                end
            end
            SBB_ST_BB: begin
                if (cmd_son && son_ok && !son_while_bb) begin
                    next_state = SBB_ST_RUN;
                end
            end
            default: next_state = SBB_ST_OFF;
        endcase
        if (hardwired_baseblock_req) begin
            next_state = SBB_ST_HARDWIRED_BASEBLOCK;
        end
    end

    // Power stage values
    // Power and brake drop straight from the request, never waiting on the state
    always_comb begin
        next_drive.motor_power = ((state == SBB_ST_RUN) | off_delay) & ~hardwired_baseblock_req;
        next_drive.brake_release_out = (state == SBB_ST_RUN) & ~hardwired_baseblock_req;
        next_drive.dynamic_brake = in_hardwired_baseblock & stop_method_select;
        next_drive.external_device_monitor_out = both_off;
    end

    // State and drive outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= SBB_ST_OFF;
            drive <= '0;
        end else begin
            state <= next_state;
            drive <= next_drive;
        end
    end

    // Servo-on during baseblock: cleared only by a different command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            son_while_bb <= 1'b0;
        end else if (cmd_son && (in_hardwired_baseblock || hardwired_baseblock_req)) begin
            son_while_bb <= 1'b1;
        end else if (cmd_other && !hardwired_baseblock_req && state == SBB_ST_BB) begin
            son_while_bb <= 1'b0;
        end else if (state == SBB_ST_RUN) begin
            son_while_bb <= 1'b0;
        end
    end

    // Command warning: set wins over alarm clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_warning <= 1'b0;
        end else if (enter_hardwired_baseblock && was_active) begin
            cmd_warning <= 1'b1;
        end else if (cmd_aclr) begin
            cmd_warning <= 1'b0;
        end
    end

    // Interrupted moving utility stays locked until the mode is left
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            util_locked <= 1'b0;
        end else if (enter_hardwired_baseblock && util_mode && util_move) begin
            util_locked <= 1'b1;
        end else if (!util_mode) begin
            util_locked <= 1'b0;
        end
    end

    // Channel disagreement timer
    // Counter saturates, so a very long disagreement can never wrap back to zero
    wire mismatch = filt_on[0] ^ filt_on[1];
    wire mm_limit = (mismatch_cnt == 32'(MISMATCH_CYC));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mismatch_cnt <= '0;
        end else if (!mismatch) begin
            mismatch_cnt <= '0;
        end else if (!mm_limit) begin
            mismatch_cnt <= mismatch_cnt + 32'h00000001;
        end
    end

    // Timing alarm sticky; clear refused while still disagreeing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timing_alarm <= 1'b0;
        end else if (mm_limit) begin
            timing_alarm <= 1'b1;
        end else if (cmd_aclr && !mismatch) begin
            timing_alarm <= 1'b0;
        end
    end

    // Brake-to-servo-off delay on a normal servo-off only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            off_delay_cnt <= '0;
        end else if (hardwired_baseblock_req) begin
            off_delay_cnt <= '0;
        end else if (state == SBB_ST_RUN && cmd_soff) begin
            off_delay_cnt <= bk_delay;
        end else if (off_delay) begin
            off_delay_cnt <= off_delay_cnt - 24'h000001;
        end
    end

    // Software-writable registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl     <= SBB_CTRL_RESET;
            bk_delay <= SBB_BKDELAY_RESET;
        end else if (wr && hit_ctrl) begin
            ctrl <= pwdata[4:0];
        end else if (wr && hit_bkd) begin
            bk_delay <= pwdata[23:0];
        end
    end

    // Status view
    sbb_status_t status;
    always_comb begin
        status.safety_input_monitor = filt_on;
        status.utility_locked       = util_locked;
        status.input_timing_alarm   = timing_alarm;
        status.command_warning      = cmd_warning;
        status.hardwired_baseblock  = in_hardwired_baseblock;
        status.servo_on_status      = (state == SBB_ST_RUN);
    end

    // Utility functions blocked by baseblock or an unfinished cancel
    assign utility_enable = util_mode & ~util_locked & ~in_hardwired_baseblock;

    // Read mux; IO monitor carries the baseblock flag at bit 10
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        if (hit_ctrl) begin
            rd_mux = {27'h0000000, ctrl};
        end else if (hit_stat) begin
            rd_mux = {25'h0000000, status};
        end else if (hit_iom) begin
            rd_mux[SBB_IOMON_HBB] = in_hardwired_baseblock;
        end else if (hit_bkd) begin
            rd_mux = {8'h00, bk_delay};
        end
    end

    // Read data captured in the setup cycle, stable through access
    // Trade-off: sampling one cycle early keeps prdata registered with no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // Zero-wait slave; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

endmodule : sbb_safety_baseblock

`default_nettype wire

// [test/sbb_props.sv]
`timescale 1ns/1ps
`default_nettype none

module sbb_props
    import sbb_pkg::*;
#(
    parameter int FILT_CYC     = 20,
    parameter int MISMATCH_CYC = 200
) (
    // Clock, reset and APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    // Safety lines and power stage
    input wire logic        safety_request_a_n,
    input wire logic        safety_request_b_n,
    input wire sbb_drive_t  drive,
    input wire logic        utility_enable
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    localparam int LONG = FILT_CYC + 4;
    int   lo_a;
    int   lo_b;
    int   hi_ab;
    int   up;
    logic db_sel;
    // Decoded access kinds
    wire acc    = psel && penable;
    wire rd_st  = acc && !pwrite && paddr == SBB_OFF_STATUS;
    wire rd_io  = acc && !pwrite && paddr == SBB_OFF_IOMON;
    wire mapped = paddr inside {SBB_OFF_CTRL, SBB_OFF_CMD, SBB_OFF_STATUS, SBB_OFF_IOMON,
                                SBB_OFF_BKDELAY};
    wire bb_req = lo_a >= LONG || lo_b >= LONG;
    // Saturating run-length counters; saturation keeps them from wrapping in long idles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lo_a   <= 0;
            lo_b   <= 0;
            hi_ab  <= 0;
            up     <= 0;
            db_sel <= SBB_CTRL_RESET[SBB_CTRL_STOP_DB];
        end else begin
            lo_a  <= safety_request_a_n ? 0 : (lo_a < 999 ? lo_a + 1 : lo_a);
            lo_b  <= safety_request_b_n ? 0 : (lo_b < 999 ? lo_b + 1 : lo_b);
            hi_ab <= !(safety_request_a_n && safety_request_b_n) ? 0 :
                     (hi_ab < 99 ? hi_ab + 1 : hi_ab);
            up    <= up < 9 ? up + 1 : up;
            if (acc && pwrite && paddr == SBB_OFF_CTRL) db_sel <= pwdata[SBB_CTRL_STOP_DB];
        end
    end

    zero_wait_a: assert property (pready) else $error("pready low");
    unmapped_err_a: assert property (acc |-> pslverr == !mapped) else $error("pslverr wrong");
    power_cut_a: assert property (bb_req |-> !drive.motor_power)
        else $error("motor power kept in baseblock");
    brake_drop_a: assert property (bb_req |-> !drive.brake_release_out)
        else $error("brake still released");
    dyn_brake_a: assert property (bb_req && db_sel |-> drive.dynamic_brake)
        else $error("dynamic brake off");
    edm_cause_a: assert property (up > 4 && $rose(drive.external_device_monitor_out)
        |-> lo_a >= FILT_CYC && lo_b >= FILT_CYC) else $error("monitor rose early");
    edm_follow_a: assert property (lo_a >= LONG && lo_b >= LONG
        |-> drive.external_device_monitor_out) else $error("monitor not on");
    edm_release_a: assert property (up > 4 && $rose(safety_request_a_n)
        |-> ##[1:3] !drive.external_device_monitor_out) else $error("monitor not off");
    io_flag_a: assert property (rd_io && bb_req |-> prdata[SBB_IOMON_HBB])
        else $error("baseblock flag clear");
    servo_on_status_zero_a: assert property (rd_st && bb_req |-> !prdata[0])
        else $error("servo on in baseblock");
    in_mon_a: assert property (rd_st && up > 4 && hi_ab >= 4 |-> prdata[6:5] == 2'b11)
        else $error("input monitor wrong");
endmodule : sbb_props

bind sbb_safety_baseblock sbb_props #(.FILT_CYC(FILT_CYC), .MISMATCH_CYC(MISMATCH_CYC)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .safety_request_a_n(safety_request_a_n), .safety_request_b_n(safety_request_b_n),
    .drive(drive), .utility_enable(utility_enable));

`default_nettype wire

// [test/sbb_safety_unit.sv]
`timescale 1ns/1ps
`default_nettype none

// External safety unit: two redundant lines, plus a short-pulse generator on line a
module sbb_safety_unit (
    // Clock and reset
    input wire logic       pclk,
    input wire logic       presetn,
    // Requests from the bench
    input wire logic       off_a,
    input wire logic       off_b,
    input wire logic       glitch_go,
    input wire logic [7:0] glitch_len,
    // Safety lines, low requests baseblock
    output logic           safety_request_a_n,
    output logic           safety_request_b_n
);
    logic [7:0] pulse_left;
    // Pulse lasts exactly glitch_len cycles
    wire next_a_n = !(off_a || pulse_left != 8'h00);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            safety_request_a_n <= 1'b1;
            safety_request_b_n <= 1'b1;
            pulse_left         <= 8'h00;
        end else begin
            safety_request_a_n <= next_a_n;
            safety_request_b_n <= !off_b;
            pulse_left <= glitch_go ? glitch_len :
                          (pulse_left != 8'h00 ? pulse_left - 8'h01 : 8'h00);
        end
    end
endmodule : sbb_safety_unit

`default_nettype wire

// [test/safety_baseblock_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module safety_baseblock_control_tb;
    import sbb_pkg::*;
    localparam int FILT = 20;
    localparam int MIS  = 200;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slv;
    logic [7:0]  paddr = 8'h00, glitch_len = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    logic        off_a = 0, off_b = 0, glitch_go = 0;
    wire         pready, pslverr, utility_enable, a_n, b_n;
    wire [31:0]  prdata;
    sbb_drive_t  drive;
    int          num_errors = 0, tests_run = 0, seed = 70, len;
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end

    always #12.5 pclk = ~pclk;

    sbb_safety_baseblock #(.FILT_CYC(FILT), .MISMATCH_CYC(MIS)) u_dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .safety_request_a_n(a_n), .safety_request_b_n(b_n), .drive(drive),
        .utility_enable(utility_enable));
    sbb_safety_unit u_unit (.pclk(pclk), .presetn(presetn), .off_a(off_a), .off_b(off_b),
        .glitch_go(glitch_go), .glitch_len(glitch_len), .safety_request_a_n(a_n),
        .safety_request_b_n(b_n));

    task report_and_stop();
        if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    // One APB transfer; request held until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin num_errors++; report_and_stop(); end
            @(posedge pclk);
        end
        slv = pslverr;
        rd = prdata;
        psel <= 0; penable <= 0;
    endtask : apb
    task chk_rd(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(0, a, 32'h0);
        `CHK(n, e, rd & m)
    endtask : chk_rd
    task cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : cyc
    task set_off(input logic a, input logic b);
        @(posedge pclk);
        off_a <= a; off_b <= b;
    endtask : set_off
    // Expected status word
    function automatic logic [31:0] stw(logic sv, logic hb, logic wn, logic al, logic lk,
                                        logic [1:0] mon);
        return {25'h0, mon, lk, al, wn, hb, sv};
    endfunction : stw

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        chk_rd("ctrl", SBB_OFF_CTRL, 32'h1f, {27'h0, SBB_CTRL_RESET});
        chk_rd("bkdelay", SBB_OFF_BKDELAY, 32'hffffff, {8'h0, SBB_BKDELAY_RESET});
        chk_rd("cmd", SBB_OFF_CMD, 32'hffffffff, 32'h0);
        chk_rd("unmapped", 8'h14, 32'hffffffff, 32'h0);
        `CHK("slverr", 1'b1, slv)
        apb(1, SBB_OFF_STATUS, 32'hffffffff);
        chk_rd("plain bb", SBB_OFF_STATUS, 32'h7f, stw(0, 0, 0, 0, 0, 2'b11));
        apb(1, SBB_OFF_CMD, {24'h0, SBB_CMD_SERVO_ON});
        chk_rd("run", SBB_OFF_STATUS, 32'h7f, stw(1, 0, 0, 0, 0, 2'b11));
        // Short pulses, longest allowed first
        for (int i = 0; i < 6; i++) begin
            len = (i == 0) ? FILT : ($unsigned($random(seed)) % FILT) + 1;
            @(posedge pclk); glitch_len <= len[7:0]; glitch_go <= 1;
            @(posedge pclk); glitch_go <= 0;
            cyc(len + 6);
            `CHK("pulse power", 2'b11, {drive.motor_power, drive.brake_release_out})
        end
        apb(1, SBB_OFF_CTRL, 32'h11);
        set_off(1, 1);
        cyc(FILT + 6);
        `CHK("bb drive", 4'b0011, drive)
        chk_rd("io flag", SBB_OFF_IOMON, 32'h400, 32'h400);
        chk_rd("hardwired_baseblock", SBB_OFF_STATUS, 32'h7f, stw(0, 1, 1, 0, 0, 2'b00));
        apb(1, SBB_OFF_CMD, {24'h0, SBB_CMD_ALM_CLR});
        apb(1, SBB_OFF_CMD, {24'h0, SBB_CMD_SERVO_ON});
        set_off(0, 0);
        cyc(4);
        chk_rd("io clear", SBB_OFF_IOMON, 32'h400, 32'h0);
        apb(1, SBB_OFF_CMD, {24'h0, SBB_CMD_SERVO_ON});
        chk_rd("refused", SBB_OFF_STATUS, 32'h7f, stw(0, 0, 0, 0, 0, 2'b11));
        apb(1, SBB_OFF_CMD, {24'h0, SBB_CMD_SERVO_OFF});
        apb(1, SBB_OFF_CMD, {24'h0, SBB_CMD_SERVO_ON});
        chk_rd("resumed", SBB_OFF_STATUS, 32'h7f, stw(1, 0, 0, 0, 0, 2'b11));
        // Normal servo-off: brake drops at once, power held for the off delay
        apb(1, SBB_OFF_BKDELAY, 32'h00000008);
        chk_rd("bkdelay wr", SBB_OFF_BKDELAY, 32'hffffff, 32'h00000008);
        apb(1, SBB_OFF_CMD, {24'h0, SBB_CMD_SERVO_OFF});
        cyc(3);
        `CHK("off delay", 2'b10, {drive.motor_power, drive.brake_release_out})
        cyc(8);
        `CHK("off done", 2'b00, {drive.motor_power, drive.brake_release_out})
        // Host stops motion before dropping the lines
        apb(1, SBB_OFF_CTRL, 32'h10);
        set_off(1, 0);
        cyc(($unsigned($random(seed)) % (MIS / 2)) + FILT);
        set_off(1, 1);
        cyc(FILT + 6);
        chk_rd("lag ok", SBB_OFF_STATUS, 32'h8, 32'h0);
        set_off(0, 0);
        cyc(4);
        apb(1, SBB_OFF_CMD, {24'h0, SBB_CMD_SERVO_ON});
        cyc(2);
        `CHK("run again", 1'b1, drive.motor_power)
        set_off(1, 0);
        cyc(MIS + FILT + 10);
        `CHK("one line", 1'b0, drive.motor_power)
        chk_rd("alarm", SBB_OFF_STATUS, 32'h68, 32'h48);
        apb(1, SBB_OFF_CMD, {24'h0, SBB_CMD_ALM_CLR});
        chk_rd("alarm held", SBB_OFF_STATUS, 32'h8, 32'h8);
        set_off(0, 0);
        cyc(4);
        apb(1, SBB_OFF_CMD, {24'h0, SBB_CMD_ALM_CLR});
        chk_rd("alarm clr", SBB_OFF_STATUS, 32'h8, 32'h0);
        // Main power removed
        apb(1, SBB_OFF_CTRL, 32'h0);
        set_off(1, 1);
        cyc(FILT + 6);
        set_off(0, 0);
        cyc(4);
        chk_rd("bb kept", SBB_OFF_STATUS, 32'h2, 32'h2);
        apb(1, SBB_OFF_CMD, {24'h0, SBB_CMD_SERVO_OFF});
        chk_rd("bb freed", SBB_OFF_STATUS, 32'h2, 32'h0);
        // Moving utility interrupted by baseblock
        apb(1, SBB_OFF_CTRL, 32'h1c);
        cyc(1);
        `CHK("util en", 1'b1, utility_enable)
        apb(1, SBB_OFF_CMD, {24'h0, SBB_CMD_SERVO_ON});
        set_off(1, 1);
        cyc(FILT + 6);
        `CHK("util bb", 1'b0, drive.motor_power)
        `CHK("util bb en", 1'b0, utility_enable)
        `CHK("util bb db", 1'b0, drive.dynamic_brake)
        set_off(0, 0);
        cyc(4);
        apb(1, SBB_OFF_CMD, {24'h0, SBB_CMD_ALM_CLR});
        apb(1, SBB_OFF_CMD, {24'h0, SBB_CMD_SERVO_ON});
        chk_rd("util lock", SBB_OFF_STATUS, 32'h11, 32'h10);
        `CHK("util held", 1'b0, utility_enable)
        apb(1, SBB_OFF_CTRL, 32'h10);
        chk_rd("util free", SBB_OFF_STATUS, 32'h10, 32'h0);
        apb(1, SBB_OFF_CTRL, 32'h1c);
        cyc(1);
        `CHK("util again", 1'b1, utility_enable)
        report_and_stop();
    end

    initial begin
        repeat (100000) @(posedge pclk);
        num_errors++;
        report_and_stop();
    end
endmodule : safety_baseblock_control_tb

`default_nettype wire
